// [bench/hsdp_host.sv]
`default_nettype none
module hsdp_host (
  input wire logic i_clock,
  input wire logic i_sdo,
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels from time zero
  initial
  begin
    o_sel_n = 1'b1;
    o_sclk = 1'b1;
    o_sdi = 1'b0;
  end
  // One frame of n bits; a short n gives an aborted frame
  task automatic xfer(input logic [31:0] tx, input int n,
    output logic [31:0] rx);
    rx = 32'h0;
    repeat (4) @(posedge i_clock);
    o_sel_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    for (int i = 31; i > 31 - n; i--)
    begin
      o_sclk <= 1'b0;
      o_sdi <= tx[i];
      repeat (7) @(posedge i_clock);
      rx = {rx[30:0], i_sdo};
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clock);
    end
    o_sel_n <= 1'b1;
    o_sdi <= ~o_sdi;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`include "hsdp_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, sel_n, sclk, sdi, sdo, rd_req, fv, fr;
  logic sw1, sw2, sw3, ramp, irq_clr;
  logic [6:0] rd_addr, exp_addr;
  logic [23:0] rd_data;
  logic [31:0] fdata, rx, v;
  logic [7:0] prediv;
  logic [31:0] exp_q[$];
  int n_errors = 0, n_compared = 0, cycles = 0, n_rd = 0;
  int seed = 32'hA8D04CE3;

  hsdp_port dut (
    .i_clock(clock), .i_reset_n(reset_n),
    .i_host_select_n(sel_n), .i_host_sclk(sclk), .i_host_sdi(sdi),
    .o_host_serial_out(sdo), .i_home_switch_1(sw1),
    .i_home_switch_2(sw2), .i_home_switch_3(sw3),
    .i_ramp_event(ramp), .i_irq_clear(irq_clr),
    .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
    .o_frame_valid(fv), .i_frame_ready(fr), .o_frame_data(fdata),
    .o_driver_clock_prediv(prediv)
  );
  hsdp_host host (
    .i_clock(clock), .i_sdo(sdo),
    .o_sel_n(sel_n), .o_sclk(sclk), .o_sdi(sdi)
  );

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Full frames are noted for the consumer side
  task automatic frame(input logic [31:0] tx, input int n);
    exp_addr = tx[31:25];
    if (n == 32)
      exp_q.push_back(tx);
    host.xfer(tx, n, rx);
    repeat (6) @(posedge clock);
  endtask

  // Read of a random address with a random answer
  task automatic rd();
    v = $random(seed);
    rd_data <= v[23:0];
    frame({v[31:25] | 7'h40, 1'b1, 24'h0}, 32);
    check("read data", 32'(rx[23:0]), 32'(v[23:0]));
    check("read count", n_rd, 1);
    n_rd = 0;
  endtask

  // Free-running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard, well above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      final_report();
    end
  end

  // Consumer side: oldest note against each delivered frame
  always @(posedge clock)
    if (reset_n && fv === 1'b1 && fr === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare frame", fdata, 32'h0);
      else
        check("frame", fdata, exp_q.pop_front());
    end

  // Read requests carry the frame address
  always @(posedge clock)
    if (reset_n && rd_req === 1'b1)
    begin
      n_rd++;
      check("read addr", 32'(rd_addr), 32'(exp_addr));
    end

  initial
  begin
    reset_n = 1'b0;
    {sw1, sw2, sw3, ramp, irq_clr, fr} = 6'h01;
    rd_data = 24'h0;
    repeat (3) @(posedge clock);
    check("prediv", 32'(prediv), 32'h0F);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    check("idle out", 32'(sdo), 32'h1);
    // Back-to-back writes of the pre-divider
    repeat (3)
    begin
      v = $random(seed);
      frame({`HSDP_PREDIV_ADDR, 1'b0, 16'h0, v[7:0]}, 32);
      check("prediv", 32'(prediv), 32'(v[7:0]));
    end
    // Aborted frame changes nothing
    frame({`HSDP_PREDIV_ADDR, 1'b0, 24'hA5}, 16);
    check("prediv", 32'(prediv), 32'(v[7:0]));
    check("read count", n_rd, 0);
    rd();
    check("status irq", 32'(rx[31]), 32'h1);
    // Each interrupt source, shown idle and inside a frame
    for (int s = 0; s < 4; s++)
    begin
      {sw3, sw2, sw1} <= 3'(1 << s);
      ramp <= (s == 3);
      @(posedge clock);
      ramp <= 1'b0;
      repeat (10) @(posedge clock);
      check("irq out", 32'(sdo), 32'h0);
      rd();
      check("status", 32'(rx[31:28]), 32'({1'b0, sw3, sw2, sw1}));
      {sw3, sw2, sw1} <= 3'h0;
      repeat (10) @(posedge clock);
      irq_clr <= 1'b1;
      @(posedge clock);
      irq_clr <= 1'b0;
      repeat (10) @(posedge clock);
      check("irq out", 32'(sdo), 32'h1);
    end
    // Stall the consumer past full; the held frame is replaced
    fr <= 1'b0;
    for (int k = 0; k < 34; k++)
    begin
      v = $random(seed);
      frame({7'h01, 1'b0, v[23:0]}, 32);
    end
    exp_q.delete(32);
    check("full valid", 32'(fv), 32'h1);
    fr <= 1'b1;
    repeat (60) @(posedge clock);
    check("drained", exp_q.size(), 0);
    check("empty", 32'(fv), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire

// [rtl/hsdp_defs.svh]
`ifndef HSDP_DEFS_SVH
`define HSDP_DEFS_SVH

// Frame layout
`define HSDP_FRAME_BITS 6'h20
`define HSDP_CNT_W 6
`define HSDP_RW_BIT 24
`define HSDP_RW_CNT 6'h07
`define HSDP_DATA_CNT 6'h08
`define HSDP_ADDR_HI 6
`define HSDP_DATA_W 24
`define HSDP_TX_LO 7
`define HSDP_TX_HI 30
`define HSDP_STAT_W 8

// Pin vector positions after synchronisation
`define HSDP_PIN_SEL 0
`define HSDP_PIN_SCK 1
`define HSDP_PIN_SDI 2
`define HSDP_PIN_SW_LO 3
`define HSDP_PIN_SW_HI 5
`define HSDP_PINS 6
`define HSDP_PIN_RST 6'h03

// Driver clock pre-divider register
`define HSDP_PREDIV_W 8
`define HSDP_PREDIV_RST 8'h0F
`define HSDP_PREDIV_ADDR 7'h3C

// Buffering
`define HSDP_FIFO_DEPTH 32

`endif

// [rtl/hsdp_pkg.sv]
`default_nettype none
package hsdp_pkg;
  // Frame engine states, one-hot
  typedef enum logic [1:0]
  {
    HSDP_IDLE = 2'h1,
    HSDP_SHIFT = 2'h2
  } hsdp_state_t;
endpackage
`default_nettype wire

// [rtl/hsdp_port.sv]
`include "hsdp_defs.svh"
`default_nettype none

module hsdp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `HSDP_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;
  wire ptr_same = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];

  // Full when the indices meet with opposite wrap bits
  assign o_in_ready = ~(ptr_same & (wr_ptr_ff[AW] != rd_ptr_ff[AW]));
  assign o_out_valid = wr_ptr_ff != rd_ptr_ff;
  assign o_out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  // Pointers
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) o_in_ready == ((AW+1)'(wr_ptr_ff - rd_ptr_ff)
    != (AW+1)'(DEPTH)))
    else $error("fifo full flag disagrees with fill level");
endmodule

module hsdp_port #(
  parameter int PREDIV_W = `HSDP_PREDIV_W,
  parameter int FIFO_DEPTH = `HSDP_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_host_select_n,
  input wire logic i_host_sclk,
  input wire logic i_host_sdi,
  output logic o_host_serial_out,
  input wire logic i_home_switch_1,
  input wire logic i_home_switch_2,
  input wire logic i_home_switch_3,
  input wire logic i_ramp_event,
  input wire logic i_irq_clear,
  output logic o_rd_req,
  output logic [`HSDP_ADDR_HI:0] o_rd_addr,
  input wire logic [`HSDP_DATA_W-1:0] i_rd_data,
  output logic o_frame_valid,
  input wire logic i_frame_ready,
  output logic [31:0] o_frame_data,
  output logic [PREDIV_W-1:0] o_driver_clock_prediv
);
  hsdp_pkg::hsdp_state_t state_ff;
  hsdp_pkg::hsdp_state_t nxt_state;
  logic [`HSDP_PINS-1:0] pins;
  logic [`HSDP_PINS-1:0] stage1_ff, stage2_ff, stage3_ff, stable_ff;
  logic [`HSDP_PINS-1:0] nxt_stable;
  logic [31:0] rx_ff, tx_ff, hold_data_ff;
  logic [`HSDP_CNT_W-1:0] cnt_ff;
  logic rd_pend_ff, hold_valid_ff, irq_pend_ff, sdo_ff, fifo_in_ready;
  logic [PREDIV_W-1:0] prediv_ff;

  assign pins = {i_home_switch_3, i_home_switch_2, i_home_switch_1,
                 i_host_sdi, i_host_sclk, i_host_select_n};

  // three stages per pin; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `HSDP_PINS; gi++)
    begin : g_sync
      wire agree = stage2_ff[gi] == stage3_ff[gi];
      assign nxt_stable[gi] = agree ? stage3_ff[gi] : stable_ff[gi];
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage1_ff <= `HSDP_PIN_RST;
      stage2_ff <= `HSDP_PIN_RST;
      stage3_ff <= `HSDP_PIN_RST;
      stable_ff <= `HSDP_PIN_RST;
    end
    else
    begin
      stage1_ff <= pins;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      stable_ff <= nxt_stable;
    end
  end

  // Edge events of the settled pins
  wire sel_fall = stable_ff[`HSDP_PIN_SEL] & ~nxt_stable[`HSDP_PIN_SEL];
  wire sel_rise = ~stable_ff[`HSDP_PIN_SEL] & nxt_stable[`HSDP_PIN_SEL];
  wire sck_rise = ~stable_ff[`HSDP_PIN_SCK] & nxt_stable[`HSDP_PIN_SCK];
  wire sck_fall = stable_ff[`HSDP_PIN_SCK] & ~nxt_stable[`HSDP_PIN_SCK];
  wire sdi_bit = nxt_stable[`HSDP_PIN_SDI];
  wire [2:0] sw_now = nxt_stable[`HSDP_PIN_SW_HI:`HSDP_PIN_SW_LO];
  wire [2:0] sw_rise = sw_now & ~stable_ff[`HSDP_PIN_SW_HI:`HSDP_PIN_SW_LO];
  wire in_shift = state_ff == hsdp_pkg::HSDP_SHIFT;

  // Frame decode
  wire full_frame = cnt_ff == `HSDP_FRAME_BITS;
  wire take = in_shift & sel_rise & full_frame;
  wire rw_now = in_shift & sck_rise & (cnt_ff == `HSDP_RW_CNT);
  // read when the direction bit is one
  wire rd_start = rw_now & sdi_bit;
  wire [`HSDP_ADDR_HI:0] frame_addr = rx_ff[31:`HSDP_RW_BIT+1];
  wire prediv_wr = take & ~rx_ff[`HSDP_RW_BIT] &
                   (frame_addr == `HSDP_PREDIV_ADDR);
  // status byte: interrupt, switches, buffer busy, zeros
  wire [`HSDP_STAT_W-1:0] status = {~irq_pend_ff, sw_now, hold_valid_ff,
                                    3'h0};
  wire sdo_nxt = stable_ff[`HSDP_PIN_SEL] ? ~irq_pend_ff : tx_ff[31];

  // Frame engine state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      hsdp_pkg::HSDP_IDLE:
        if (sel_fall)
          nxt_state = hsdp_pkg::HSDP_SHIFT;
      hsdp_pkg::HSDP_SHIFT:
        if (sel_rise)
          nxt_state = hsdp_pkg::HSDP_IDLE;
      default:
        nxt_state = hsdp_pkg::HSDP_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_ff <= hsdp_pkg::HSDP_IDLE;
    else
      state_ff <= nxt_state;
  end

  // bit counter saturates and never times out
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_ff <= '0;
    else if (sel_fall)
      cnt_ff <= '0;
    else if (in_shift & sck_rise & ~full_frame)
      cnt_ff <= cnt_ff + `HSDP_CNT_W'(1);
  end

  // shift in on rise, first bit ends up at the top
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rx_ff <= '0;
    else if (in_shift & sck_rise)
      rx_ff <= {rx_ff[30:0], sdi_bit};
  end

  // status loads at frame start; read data follows bit eight
  // Shift out on each fall but the first, which already shows bit 31
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tx_ff <= '0;
    else if (sel_fall)
      tx_ff <= {status, `HSDP_DATA_W'(0)};
    else if (rd_pend_ff)
      tx_ff[`HSDP_TX_HI:`HSDP_TX_LO] <= i_rd_data;
    else if (in_shift & sck_fall & (cnt_ff != '0))
      tx_ff <= {tx_ff[30:0], 1'b0};
  end

  // read request to the memory arbiter, answered next cycle
  assign o_rd_req = rd_start;
  assign o_rd_addr = rx_ff[`HSDP_ADDR_HI:0]; // First seven bits sit at bottom
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rd_pend_ff <= 1'b0;
    else
      rd_pend_ff <= rd_start;
  end

  // output register, always driven; at least four clocks behind pin
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sdo_ff <= 1'b1;
    else
      sdo_ff <= sdo_nxt;
  end
  assign o_host_serial_out = sdo_ff;

  // sticky interrupt; a new event wins over a clear
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      irq_pend_ff <= 1'b0;
    else if (i_ramp_event | (|sw_rise))
      irq_pend_ff <= 1'b1;
    else if (i_irq_clear)
      irq_pend_ff <= 1'b0;
  end

  // only complete frames reach the buffer; a newer frame replaces
  // one the fifo has not yet taken, since the host cannot be stalled
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hold_valid_ff <= 1'b0;
      hold_data_ff <= '0;
    end
    else if (take)
    begin
      hold_valid_ff <= 1'b1;
      hold_data_ff <= rx_ff;
    end
    else if (fifo_in_ready)
      hold_valid_ff <= 1'b0;
  end

  // pre-divider resets to 15, written by a frame after select rise
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prediv_ff <= PREDIV_W'(`HSDP_PREDIV_RST);
    else if (prediv_wr)
      prediv_ff <= rx_ff[PREDIV_W-1:0];
  end
  assign o_driver_clock_prediv = prediv_ff;

  // Frame queue toward the command decoder
  hsdp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_in_valid(hold_valid_ff),
    .o_in_ready(fifo_in_ready),
    .i_in_data(hold_data_ff),
    .o_out_valid(o_frame_valid),
    .i_out_ready(i_frame_ready),
    .o_out_data(o_frame_data)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  AST_SHIFT_IN: assert property (
    in_shift && sck_rise |=> rx_ff[0] == $past(sdi_bit))
    else $error("input bit not captured on rise");
  AST_LATCH: assert property (
    take |=> hold_valid_ff && hold_data_ff == $past(rx_ff))
    else $error("frame not copied at select rise");
  AST_ABORT: assert property (
    in_shift && sel_rise && !full_frame |=> $stable(hold_data_ff))
    else $error("short frame reached the buffer");
  AST_SDO_DELAY: assert property (
    $fell(i_host_sclk) && !stable_ff[`HSDP_PIN_SEL] && !i_host_select_n
    |=> $stable(o_host_serial_out)[*3])
    else $error("output bit changed too soon");
  AST_IRQ_MUX: assert property (
    (stable_ff[`HSDP_PIN_SEL] && irq_pend_ff)[*2] |-> !o_host_serial_out)
    else $error("interrupt not shown while idle");
  AST_PREDIV_RST: assert property (
    $past(!i_reset_n) |-> o_driver_clock_prediv == `HSDP_PREDIV_RST)
    else $error("pre-divider reset value wrong");
  AST_RD_DATA: assert property (
    o_rd_req |=> ##1 tx_ff[`HSDP_TX_HI:`HSDP_TX_LO] == $past(i_rd_data, 1))
    else $error("read data not loaded in frame");
  AST_STATUS: assert property (
    sel_fall |=> tx_ff[31] == $past(~irq_pend_ff))
    else $error("interrupt status missing from frame");
  AST_IRQ_SET: assert property (
    i_ramp_event |=> irq_pend_ff)
    else $error("ramp event lost");

  COV_WRITE_FRAME: cover property (take && !rx_ff[`HSDP_RW_BIT]);
  COV_READ_FRAME: cover property (rd_start ##[1:1000] take);
  COV_ABORT: cover property (in_shift && sel_rise && !full_frame);
  COV_IRQ_IDLE: cover property (irq_pend_ff && !o_host_serial_out);
endmodule
`default_nettype wire
